// [mtb_map.vh]
`ifndef MTB_MAP_VH
`define MTB_MAP_VH
// register byte offsets
`define MTB_CTRL        8'h00
`define MTB_TRIM        8'h04
`define MTB_CORR        8'h08
`define MTB_CORR_DIR    8'h0c
`define MTB_TOUT        8'h10
`define MTB_TIMER30     8'h14
`define MTB_TIMER24     8'h18
`define MTB_INT_STAT    8'h1c
`define MTB_INT_CLR     8'h20
`define MTB_INT_EN      8'h24
`define MTB_WAKE        8'h28
`define MTB_WAKE_DLY    8'h2c
`define MTB_STAMP_BASE  8'h40
`define MTB_STAMP_LAST  8'h5c
// ctrl fields
`define MTB_CTRL_REF16  0
`define MTB_CTRL_TOEN   1
// tick counts per ms, correction periods and layer count
`define MTB_CNT_A32     7'h41
`define MTB_CNT_B32     7'h42
`define MTB_CNT_16      7'h20
`define MTB_CORR40_MS   6'h28
`define MTB_MS_PER_S    10'h3e8
`define MTB_LAYERS      15
// irq bit positions and bus response codes
`define MTB_IRQ_MS      8
`define MTB_IRQ_TOUT    9
`define MTB_IRQ_KICK    10
`define MTB_IRQ_W       11
`define MTB_RESP_OKAY   2'h0
`define MTB_RESP_SLVERR 2'h2
`endif

// [mtb_edge_event.v]
`timescale 1ns/1ps
module mtb_edge_event (
  // clock and reset
  input  wire mclk,
  input  wire rst,
  // reference clock sampled synchronously
  input  wire ref_clk,
  // one pulse per edge
  output reg  clk_event
);
  reg ref_q;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ref_q     <= 1'b0;
      clk_event <= 1'b0;
    end else begin
      ref_q     <= ref_clk;
      clk_event <= ref_q ^ ref_clk;
    end
  end
endmodule

// [mtb_timebase.v]
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "mtb_map.vh"
module mtb_timebase (
  // clock and reset
  input  wire        mclk,
  input  wire        rst,
  // reference clock
  input  wire        ref_clk,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // time stamp interrupt sources
  input  wire [7:0]  stamp_src,
  // power manager handshake
  output reg         power_manager_req,
  input  wire        power_manager_on,
  // sensor processing engine
  output reg         sensor_processing_engine_kick,
  output reg  [23:0] sensor_processing_engine_time,
  // interrupt
  output wire        irq
);
  localparam W_IDLE = 2'd0;
  localparam W_PWR  = 2'd1;
  localparam W_DLY  = 2'd2;

  wire        clk_event;
  reg  [31:0] ctrl;
  reg  [6:0]  trim;
  reg  [31:0] corr_en;
  reg  [15:0] corr_dir;
  reg  [7:0]  tout_period;
  reg  [29:0] timer30;
  reg  [10:0] int_stat;
  reg  [10:0] int_en;
  reg  [15:0] wake_dly;
  reg  [15:0] stamp [0:7];
  reg  [6:0]  ev_cnt;
  reg         phase;
  reg  [5:0]  ms40;
  reg  [9:0]  ms_in_s;
  reg  [13:0] sec_cnt;
  reg  signed [2:0] adj;
  reg  signed [4:0] layer_sum;
  reg  signed [8:0] next_target;
  reg  [6:0]  target;
  reg         ms_tick;
  reg  [7:0]  tout_cnt;
  reg         tout_tick;
  reg  [1:0]  wstate;
  reg  [15:0] wcnt;
  reg  [7:0]  stamp_q;
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         aw_have;
  reg         w_have;
  reg  [10:0] ev_set;
  reg  [31:0] wr_old;
  wire [31:0] wr_new;
  integer     k;

  mtb_edge_event u_edge (
    .mclk      (mclk),
    .rst       (rst),
    .ref_clk   (ref_clk),
    .clk_event (clk_event)
  );

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer      b;
    begin
      for (b = 0; b < 4; b = b + 1)
        merge[b*8 +: 8] = st[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  function is_stamp;
    input [7:0] a;
    begin
      is_stamp = (a >= `MTB_STAMP_BASE) && (a <= `MTB_STAMP_LAST) &&
                 (a[1:0] == 2'b00);
    end
  endfunction

  // old word of a narrow register, for byte-lane merging
  always @* begin
    if (aw_addr == `MTB_TRIM)
      wr_old = {25'd0, trim};
    else if (aw_addr == `MTB_CORR_DIR)
      wr_old = {16'd0, corr_dir};
    else if (aw_addr == `MTB_TOUT)
      wr_old = {24'd0, tout_period};
    else if (aw_addr == `MTB_WAKE_DLY)
      wr_old = {16'd0, wake_dly};
    else if (aw_addr == `MTB_INT_EN)
      wr_old = {21'd0, int_en};
    else
      wr_old = 32'h0000_0000;
  end
  assign wr_new = merge(wr_old, w_data, w_strb);

  // correction layers due at this second boundary
  always @* begin
    layer_sum = 5'sd0;
    for (k = 0; k < `MTB_LAYERS; k = k + 1) begin
      if (corr_en[k+1] && (ms_in_s == 10'd0) &&
          ((sec_cnt & ((14'd1 << k) - 14'd1)) == 14'd0)) begin
        if (corr_dir[k])
          layer_sum = layer_sum - 5'sd1;
        else
          layer_sum = layer_sum + 5'sd1;
      end
    end
  end

  // per-millisecond event count
  always @* begin
    if (ctrl[`MTB_CTRL_REF16])
      next_target = $signed({2'b00, `MTB_CNT_16});
    else if (phase)
      next_target = $signed({2'b00, `MTB_CNT_A32});
    else
      next_target = $signed({2'b00, `MTB_CNT_B32});
    next_target = next_target + $signed({2'b00, trim}) - 9'sd64;
    adj = (corr_en[0] && ms40 == 6'd0) ? 3'sd1 : 3'sd0;
    next_target = next_target + adj + layer_sum;
    if (next_target < 9'sd1)
      next_target = 9'sd1;
    else if (next_target > 9'sd127)
      next_target = 9'sd127;
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ev_cnt  <= 7'h00;
      phase   <= 1'b0;
      ms40    <= 6'h00;
      ms_in_s <= 10'h000;
      sec_cnt <= 14'h0000;
      target  <= `MTB_CNT_A32;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= 1'b0;
      if (clk_event) begin
        if (ev_cnt + 7'd1 >= target) begin
          ev_cnt  <= 7'h00;
          ms_tick <= 1'b1;
          phase   <= ~phase;
          target  <= next_target[6:0];
          ms40    <= (ms40 == `MTB_CORR40_MS - 6'd1) ? 6'h00 : ms40 + 6'd1;
          if (ms_in_s == `MTB_MS_PER_S - 10'd1) begin
            ms_in_s <= 10'h000;
            sec_cnt <= sec_cnt + 14'd1;
          end else begin
            ms_in_s <= ms_in_s + 10'd1;
          end
        end else begin
          ev_cnt <= ev_cnt + 7'd1;
        end
      end
    end
  end

  // timeout counter
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      tout_cnt  <= 8'h00;
      tout_tick <= 1'b0;
    end else begin
      tout_tick <= 1'b0;
      if (!ctrl[`MTB_CTRL_TOEN] || tout_period == 8'h00) begin
        tout_cnt <= 8'h00;
      end else if (ms_tick) begin
        if (tout_cnt + 8'd1 >= tout_period) begin
          tout_cnt  <= 8'h00;
          tout_tick <= 1'b1;
        end else begin
          tout_cnt <= tout_cnt + 8'd1;
        end
      end
    end
  end

  // wake-up sequencer
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wstate <= W_IDLE;
      wcnt   <= 16'h0000;
      power_manager_req             <= 1'b0;
      sensor_processing_engine_kick <= 1'b0;
    end else begin
      sensor_processing_engine_kick <= 1'b0;
      case (wstate)
        W_IDLE: begin
          if (tout_tick) begin
            power_manager_req <= 1'b1;
            wstate <= W_PWR;
          end
        end
        W_PWR: begin
          if (power_manager_on) begin
            wcnt   <= wake_dly;
            wstate <= W_DLY;
          end
        end
        W_DLY: begin
          if (!power_manager_on) begin
            wstate <= W_PWR;
          end else if (ms_tick || wcnt == 16'h0000) begin
            if (wcnt == 16'h0000) begin
              sensor_processing_engine_kick <= 1'b1;
              power_manager_req <= 1'b0;
              wstate <= W_IDLE;
            end else begin
              wcnt <= wcnt - 16'd1;
            end
          end
        end
        default: wstate <= W_IDLE;
      endcase
    end
  end

  // bus handshake
  wire wr_go = aw_have && w_have && !s_axi_bvalid;
  assign s_axi_awready = !aw_have;
  assign s_axi_wready  = !w_have;
  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    ev_set = {3'b000, stamp_src & ~stamp_q};
    ev_set[`MTB_IRQ_MS]   = ms_tick;
    ev_set[`MTB_IRQ_TOUT] = tout_tick;
    ev_set[`MTB_IRQ_KICK] = sensor_processing_engine_kick;
  end
  assign irq = |(int_stat & int_en);

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MTB_RESP_OKAY;
      ctrl     <= 32'h0000_0000;
      trim     <= 7'h40;
      corr_en  <= 32'h0000_0000;
      corr_dir <= 16'h0000;
      tout_period <= 8'h00;
      wake_dly <= 16'h0000;
      int_en   <= 11'h000;
    end else begin
      if (s_axi_awvalid && !aw_have) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        aw_have <= 1'b0;
        w_have  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `MTB_RESP_OKAY;
        if (aw_addr == `MTB_CTRL)
          ctrl <= merge(ctrl, w_data, w_strb) & 32'h0000_0003;
        else if (aw_addr == `MTB_TRIM)
          trim <= wr_new[6:0];
        else if (aw_addr == `MTB_CORR)
          corr_en <= merge(corr_en, w_data, w_strb) & 32'h0000_ffff;
        else if (aw_addr == `MTB_CORR_DIR)
          corr_dir <= wr_new[15:0] & 16'h7fff;
        else if (aw_addr == `MTB_TOUT)
          tout_period <= wr_new[7:0];
        else if (aw_addr == `MTB_WAKE_DLY)
          wake_dly <= wr_new[15:0];
        else if (aw_addr == `MTB_INT_EN)
          int_en <= wr_new[10:0];
        else if (aw_addr == `MTB_TIMER30 || aw_addr == `MTB_INT_CLR)
          s_axi_bresp <= `MTB_RESP_OKAY;
        else
          s_axi_bresp <= `MTB_RESP_SLVERR;
      end
    end
  end

  // timers, stamps and status
  wire t30_wr = wr_go && aw_addr == `MTB_TIMER30;
  wire clr_wr = wr_go && aw_addr == `MTB_INT_CLR;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      timer30  <= 30'h0000_0000;
      sensor_processing_engine_time <= 24'h00_0000;
      int_stat <= 11'h000;
      stamp_q  <= 8'h00;
    end else begin
      stamp_q <= stamp_src;
      if (t30_wr)
        timer30 <= w_data[29:0];
      else if (ms_tick)
        timer30 <= timer30 + 30'd1;
      if (ms_tick)
        sensor_processing_engine_time <=
          sensor_processing_engine_time + 24'd1;
      int_stat <= (int_stat & ~(clr_wr ? w_data[10:0] : 11'h000)) | ev_set;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_stamp
      always @(posedge mclk or posedge rst) begin
        if (rst)
          stamp[g] <= 16'h0000;
        else if (stamp_src[g] && !stamp_q[g] && int_en[g])
          stamp[g] <= sensor_processing_engine_time[15:0];
      end
    end
  endgenerate

  // read channel
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `MTB_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `MTB_RESP_OKAY;
      if (s_axi_araddr == `MTB_CTRL)
        s_axi_rdata <= ctrl;
      else if (s_axi_araddr == `MTB_TRIM)
        s_axi_rdata <= {25'd0, trim};
      else if (s_axi_araddr == `MTB_CORR)
        s_axi_rdata <= corr_en;
      else if (s_axi_araddr == `MTB_CORR_DIR)
        s_axi_rdata <= {16'd0, corr_dir};
      else if (s_axi_araddr == `MTB_TOUT)
        s_axi_rdata <= {24'd0, tout_period};
      else if (s_axi_araddr == `MTB_TIMER30)
        s_axi_rdata <= {2'b00, timer30};
      else if (s_axi_araddr == `MTB_TIMER24)
        s_axi_rdata <= {8'd0, sensor_processing_engine_time};
      else if (s_axi_araddr == `MTB_INT_STAT)
        s_axi_rdata <= {21'd0, int_stat};
      else if (s_axi_araddr == `MTB_INT_EN)
        s_axi_rdata <= {21'd0, int_en};
      else if (s_axi_araddr == `MTB_WAKE)
        s_axi_rdata <= {29'd0, wstate == W_DLY, wstate == W_PWR,
                        power_manager_req};
      else if (s_axi_araddr == `MTB_WAKE_DLY)
        s_axi_rdata <= {16'd0, wake_dly};
      else if (is_stamp(s_axi_araddr))
        s_axi_rdata <= {16'd0, stamp[s_axi_araddr[4:2]]};
      else if (s_axi_araddr == `MTB_INT_CLR) begin
        s_axi_rdata <= 32'h0000_0000;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `MTB_RESP_SLVERR;
      end
    end
  end
endmodule

// [mtb_timebase_assertions.sv]
`timescale 1ns/1ps
module mtb_timebase_chk (
  // clock and reset
  input wire        mclk,
  input wire        rst,
  // register bus
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  // wake and engine
  input wire        power_manager_req,
  input wire        power_manager_on,
  input wire        sensor_processing_engine_kick,
  input wire [23:0] sensor_processing_engine_time
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during answer");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  kick_pulse_a: assert property (sensor_processing_engine_kick
    |=> !sensor_processing_engine_kick) else $error("kick too long");
  kick_after_on_a: assert property (sensor_processing_engine_kick
    |-> $past(power_manager_on)) else $error("kick before power");
  req_wait_a: assert property (power_manager_req && !power_manager_on
    |=> power_manager_req) else $error("request withdrawn");
  time_step_a: assert property ($changed(sensor_processing_engine_time)
    |-> sensor_processing_engine_time ==
        $past(sensor_processing_engine_time) + 24'h1)
    else $error("timer jumped");
endmodule
bind mtb_timebase mtb_timebase_chk u_chk (
  .mclk                          (mclk),
  .rst                           (rst),
  .s_axi_awvalid                 (s_axi_awvalid),
  .s_axi_awready                 (s_axi_awready),
  .s_axi_wvalid                  (s_axi_wvalid),
  .s_axi_wready                  (s_axi_wready),
  .s_axi_arvalid                 (s_axi_arvalid),
  .s_axi_arready                 (s_axi_arready),
  .s_axi_rdata                   (s_axi_rdata),
  .s_axi_rvalid                  (s_axi_rvalid),
  .s_axi_rready                  (s_axi_rready),
  .s_axi_bresp                   (s_axi_bresp),
  .s_axi_bvalid                  (s_axi_bvalid),
  .s_axi_bready                  (s_axi_bready),
  .power_manager_req             (power_manager_req),
  .power_manager_on              (power_manager_on),
  .sensor_processing_engine_kick (sensor_processing_engine_kick),
  .sensor_processing_engine_time (sensor_processing_engine_time)
);

// [mtb_pwr_model.sv]
`timescale 1ns/1ps
module mtb_pwr_model #(
  parameter DLY = 10
) (
  // clock and reset
  input  wire mclk,
  input  wire rst,
  // power handshake
  input  wire power_manager_req,
  output reg  power_manager_on
);
  integer cnt;
  // domain comes up some cycles after request, drops once released
  always @(posedge mclk or posedge rst) begin
    if (rst || !power_manager_req) begin
      cnt <= 0;
      power_manager_on <= 1'b0;
    end else if (cnt == DLY) begin
      power_manager_on <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// [mtb_timebase_bench.sv]
`timescale 1ns/1ps
`include "mtb_map.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
`define WAITN(x) c = 0; \
  while (!(x) && c < 9000) begin @(negedge mclk); c++; end \
  if (!(x)) bad_count++;
module mtb_timebase_bench;
  reg         mclk, rst, ref_clk, s_axi_awvalid, s_axi_wvalid;
  reg         s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr, stamp_src;
  reg  [31:0] s_axi_wdata, d;
  reg  [3:0]  s_axi_wstrb;
  reg  [1:0]  r, rdiv;
  reg  [23:0] t0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, irq;
  wire        s_axi_arready, s_axi_rvalid, power_manager_req;
  wire        power_manager_on, sensor_processing_engine_kick;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [23:0] sensor_processing_engine_time;
  integer     bad_count, compares, c, c1, c2, k;
  mtb_timebase u_dut (
    .mclk                          (mclk),
    .rst                           (rst),
    .ref_clk                       (ref_clk),
    .s_axi_awaddr                  (s_axi_awaddr),
    .s_axi_awvalid                 (s_axi_awvalid),
    .s_axi_awready                 (s_axi_awready),
    .s_axi_wdata                   (s_axi_wdata),
    .s_axi_wstrb                   (s_axi_wstrb),
    .s_axi_wvalid                  (s_axi_wvalid),
    .s_axi_wready                  (s_axi_wready),
    .s_axi_bresp                   (s_axi_bresp),
    .s_axi_bvalid                  (s_axi_bvalid),
    .s_axi_bready                  (s_axi_bready),
    .s_axi_araddr                  (s_axi_araddr),
    .s_axi_arvalid                 (s_axi_arvalid),
    .s_axi_arready                 (s_axi_arready),
    .s_axi_rdata                   (s_axi_rdata),
    .s_axi_rresp                   (s_axi_rresp),
    .s_axi_rvalid                  (s_axi_rvalid),
    .s_axi_rready                  (s_axi_rready),
    .stamp_src                     (stamp_src),
    .power_manager_req             (power_manager_req),
    .power_manager_on              (power_manager_on),
    .sensor_processing_engine_kick (sensor_processing_engine_kick),
    .sensor_processing_engine_time (sensor_processing_engine_time),
    .irq                           (irq)
  );
  mtb_pwr_model u_pwr (.mclk(mclk), .rst(rst),
    .power_manager_req(power_manager_req),
    .power_manager_on(power_manager_on));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // fast reference: one edge every four clocks keeps the run short
  always @(posedge mclk) begin
    rdiv <= rdiv + 2'h1;
    if (rdiv == 2'h3) ref_clk <= ~ref_clk;
  end
  task wr(input [7:0] a, input [31:0] v);
    reg pa, pw, pb, ta, tw, tb;
    begin
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      {pa, pw, pb} = 3'h7;
      while ({pa, pw, pb} != 3'h0) begin
        @(negedge mclk);
        ta = pa && s_axi_awready;
        tw = pw && s_axi_wready;
        tb = pb && s_axi_bvalid;
        if (tb) r = s_axi_bresp;
        @(posedge mclk);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
        if (tb) s_axi_bready <= 1'b0;
        {pa, pw, pb} = {pa & ~ta, pw & ~tw, pb & ~tb};
      end
    end
  endtask
  task rd(input [7:0] a);
    reg pa, pb, ta, tb;
    begin
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      {pa, pb} = 2'h3;
      while ({pa, pb} != 2'h0) begin
        @(negedge mclk);
        ta = pa && s_axi_arready;
        tb = pb && s_axi_rvalid;
        if (tb) {r, d} = {s_axi_rresp, s_axi_rdata};
        @(posedge mclk);
        if (ta) s_axi_arvalid <= 1'b0;
        if (tb) s_axi_rready <= 1'b0;
        {pa, pb} = {pa & ~ta, pb & ~tb};
      end
    end
  endtask
  // cycles until the millisecond timer next moves
  task gap(output integer g);
    reg [23:0] tv;
    begin
      @(negedge mclk);
      tv = sensor_processing_engine_time;
      g = 1;
      while (sensor_processing_engine_time === tv && g < 3000) begin
        @(negedge mclk);
        g++;
      end
      if (sensor_processing_engine_time === tv) bad_count++;
    end
  endtask
  task t_regs;
    begin
      rd(`MTB_TRIM);
      `CHK(d, 32'h40)
      rd(8'h30);
      `CHK({r, d}, {2'h2, 32'h0})
      wr(8'h30, 32'h1);
      `CHK(r, 2'h2)
      $display("done regs");
    end
  endtask
  task t_period(input [31:0] ctl, input [31:0] trim, input integer want);
    begin
      wr(`MTB_CTRL, ctl);
      wr(`MTB_TRIM, trim);
      gap(c);
      gap(c);
      gap(c1);
      gap(c2);
      `CHK(c1 + c2, want)
      $display("done period %0d", want);
    end
  endtask
  task t_corr;
    begin
      wr(`MTB_CORR, 32'h1);
      gap(c);
      c2 = 0;
      for (k = 0; k < 40; k++) begin
        gap(c);
        c2 = c2 + c;
      end
      `CHK(c2, 10484)
      wr(`MTB_CORR, 32'h0);
      $display("done corr");
    end
  endtask
  // one-second layer over a full second of short milliseconds
  task t_layer(input [31:0] trimv, input [31:0] dir, input integer want);
    begin
      wr(`MTB_CORR_DIR, dir);
      wr(`MTB_CORR, 32'h2);
      wr(`MTB_TRIM, trimv);
      gap(c);
      gap(c);
      c2 = 0;
      for (k = 0; k < 1000; k++) begin
        gap(c);
        c2 = c2 + c;
      end
      `CHK(c2, want)
      wr(`MTB_CORR, 32'h0);
      wr(`MTB_TRIM, 32'h40);
      $display("done layer %0d", want);
    end
  endtask
  task t_timer;
    begin
      gap(c);
      wr(`MTB_TIMER30, 32'h3fff_fffe);
      gap(c);
      gap(c);
      gap(c);
      rd(`MTB_TIMER30);
      `CHK(d, 32'h1)
      $display("done timer");
    end
  endtask
  task t_stamp;
    begin
      wr(`MTB_INT_EN, 32'h1);
      gap(c);
      @(posedge mclk);
      stamp_src <= 8'h03;
      repeat (4) @(negedge mclk);
      t0 = sensor_processing_engine_time;
      rd(`MTB_STAMP_BASE);
      `CHK(d, {16'h0, t0[15:0]})
      rd(`MTB_STAMP_BASE + 8'h04);
      `CHK(d, 32'h0)
      rd(`MTB_INT_STAT);
      `CHK(d[1:0], 2'h3)
      `CHK(irq, 1'b1)
      wr(`MTB_INT_CLR, 32'h3);
      stamp_src <= 8'h00;
      @(negedge mclk);
      `CHK(irq, 1'b0)
      $display("done stamp");
    end
  endtask
  task t_wake;
    begin
      wr(`MTB_WAKE_DLY, 32'h2);
      wr(`MTB_INT_EN, 32'h200);
      wr(`MTB_TOUT, 32'h3);
      wr(`MTB_CTRL, 32'h2);
      `WAITN(power_manager_on)
      `CHK(power_manager_req, 1'b1)
      t0 = sensor_processing_engine_time;
      `WAITN(sensor_processing_engine_kick)
      `CHK(power_manager_on, 1'b1)
      `CHK(power_manager_req, 1'b0)
      `CHK(sensor_processing_engine_time - t0, 24'h2)
      wr(`MTB_INT_CLR, 32'h200);
      `WAITN(irq)
      t0 = sensor_processing_engine_time;
      wr(`MTB_TOUT, 32'h5);
      wr(`MTB_INT_CLR, 32'h200);
      `WAITN(irq)
      `CHK(sensor_processing_engine_time - t0, 24'h5)
      wr(`MTB_CTRL, 32'h0);
      $display("done wake");
    end
  endtask
  task report_and_stop;
    begin
      $display("compares %0d bad %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    bad_count++;
    report_and_stop;
  end
  initial begin
    rst = 1'b1;
    {ref_clk, rdiv, stamp_src} = 11'h000;
    bad_count = 0;
    compares = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_regs;
    t_period(32'h0, 32'h42, 540);
    t_period(32'h1, 32'h40, 256);
    t_period(32'h0, 32'h40, 524);
    t_corr;
    t_layer(32'h00, 32'h0, 6004);
    t_layer(32'h01, 32'h1, 9996);
    t_timer;
    t_stamp;
    t_wake;
    report_and_stop;
  end
endmodule
